// ### include/dpg_defines.svh
// register offsets, field positions, reset values for the dual gpio block
// assumes an 8-bit register port with a 3-bit word address
`ifndef DPG_DEFINES_SVH
`define DPG_DEFINES_SVH

`define DPG_AW           3
`define DPG_OFS_PD_PIN   3'h0
`define DPG_OFS_PD_LAT   3'h1
`define DPG_OFS_PD_DIR   3'h2
`define DPG_OFS_PE_PIN   3'h3
`define DPG_OFS_PE_LAT   3'h4
`define DPG_OFS_PE_DIR   3'h5
`define DPG_OFS_SLVCTL   3'h6
`define DPG_OFS_EXTMEM   3'h7

`define DPG_EXT_BUSOFF   7
`define DPG_SLV_INFULL   7
`define DPG_SLV_OUTFULL  6
`define DPG_SLV_INOVF    5
`define DPG_SLV_MODE     4
`define DPG_PE_RD_N      0
`define DPG_PE_WR_N      1
`define DPG_PE_CS_N      2
`define DPG_PE_CCP2      7

`define DPG_MEM_WMASK    8'hb3
`define DPG_RST_DIR      8'hff
`define DPG_RST_LAT      8'h00
`define DPG_RST_SLVCTL   8'h00
`define DPG_RST_EXTMEM   8'h00

`endif

// ### include/dpg_pkg.sv
// types shared by the dual gpio block
// assumes nothing beyond a SystemVerilog compiler
package dpg_pkg;

   typedef enum logic [1:0] {
      DPG_MODE_MCU,
      DPG_MODE_MPU,
      DPG_MODE_EXT_MCU
   } dpg_mem_mode_t;

   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe;
   } dpg_drive_t;

   typedef struct packed {
      logic [15:0] ad_out;
      logic        oe;
   } dpg_bus_drive_t;

endpackage

// ### design/dpg_gpio.sv
// two 8-bit i/o ports shared with the muxed memory bus and slave port
// assumes pins and straps are asynchronous; bus controller on i_ref_clk
`include "dpg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dpg_gpio
   import dpg_pkg::*;
(
   input  wire logic               i_ref_clk,
   input  wire logic               i_rst_n,
   input  wire logic [`DPG_AW-1:0] i_addr,
   input  wire logic [7:0]         i_wdata,
   input  wire logic               i_wr,
   input  wire logic               i_rd,
   output logic [7:0]              o_rdata,
   input  wire logic [7:0]         i_pd_pin,
   output dpg_drive_t              o_pd_drv,
   input  wire logic [7:0]         i_pe_pin,
   output dpg_drive_t              o_pe_drv,
   input  wire dpg_mem_mode_t      i_mem_mode,
   input  wire logic               i_capture_unit2_pin_select,
   input  wire dpg_bus_drive_t     i_bus,
   output logic [15:0]             o_bus_ad_in,
   input  wire logic               i_ccp2_out,
   input  wire logic               i_ccp2_oe,
   output logic                    o_ccp2_in,
   output logic                    o_pd_ttl_sel,
   output logic                    o_pe_ttl_sel
);

   // pin and strap synchronisers
   logic [7:0]    pd_s1_reg;
   logic [7:0]    pd_s2_reg;
   logic [7:0]    pe_s1_reg;
   logic [7:0]    pe_s2_reg;
   dpg_mem_mode_t mode_s1_reg;
   dpg_mem_mode_t mode_s2_reg;
   logic          cmx_s1_reg;
   logic          cmx_s2_reg;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pd_s1_reg   <= 8'h00;
         pd_s2_reg   <= 8'h00;
         pe_s1_reg   <= 8'hff;
         pe_s2_reg   <= 8'hff;
         mode_s1_reg <= DPG_MODE_MCU;
         mode_s2_reg <= DPG_MODE_MCU;
         cmx_s1_reg  <= 1'b1;
         cmx_s2_reg  <= 1'b1;
      end else begin
         pd_s1_reg   <= i_pd_pin;
         pd_s2_reg   <= pd_s1_reg;
         pe_s1_reg   <= i_pe_pin;
         pe_s2_reg   <= pe_s1_reg;
         mode_s1_reg <= i_mem_mode;
         mode_s2_reg <= mode_s1_reg;
         cmx_s1_reg  <= i_capture_unit2_pin_select;
         cmx_s2_reg  <= cmx_s1_reg;
      end
   end

   // software-visible state
   logic [7:0] lat_d_reg;
   logic [7:0] lat_d_next;
   logic [7:0] dir_d_reg;
   logic [7:0] dir_d_next;
   logic [7:0] lat_e_reg;
   logic [7:0] lat_e_next;
   logic [7:0] dir_e_reg;
   logic [7:0] dir_e_next;
   logic [7:0] extmem_reg;
   logic [7:0] extmem_next;
   logic       slv_mode_reg;
   logic       slv_mode_next;
   logic       in_full_reg;
   logic       in_full_next;
   logic       out_full_reg;
   logic       out_full_next;
   logic       in_ovf_reg;
   logic       in_ovf_next;
   logic [7:0] slv_in_reg;
   logic [7:0] slv_in_next;
   logic       wr_n_prev_reg;
   logic       rd_n_prev_reg;
   logic [7:0] rdata_next;

   // mode decode
   logic bus_off;
   logic is_mcu;
   logic ext_bus;
   logic slv_on;
   logic host_cs;
   logic host_rd;
   logic wr_end;
   logic rd_end;
   logic ccp_alt;

   always_comb begin
      bus_off = extmem_reg[`DPG_EXT_BUSOFF];
      is_mcu  = (mode_s2_reg == DPG_MODE_MCU);
      // bus owns both ports unless disabled or no external memory
      ext_bus = !bus_off && !is_mcu;
      slv_on  = is_mcu && slv_mode_reg;
      host_cs = slv_on && !pe_s2_reg[`DPG_PE_CS_N];
      host_rd = host_cs && !pe_s2_reg[`DPG_PE_RD_N];
      // capture at the trailing edge so the data have settled
      wr_end  = host_cs && pe_s2_reg[`DPG_PE_WR_N]
                && !wr_n_prev_reg;
      rd_end  = host_cs && pe_s2_reg[`DPG_PE_RD_N] && !rd_n_prev_reg;
      ccp_alt = is_mcu && !cmx_s2_reg;
   end

   // register writes, flags and read mux
   always_comb begin
      lat_d_next    = lat_d_reg;
      dir_d_next    = dir_d_reg;
      lat_e_next    = lat_e_reg;
      dir_e_next    = dir_e_reg;
      extmem_next   = extmem_reg;
      slv_mode_next = slv_mode_reg;
      in_full_next  = in_full_reg;
      out_full_next = out_full_reg;
      in_ovf_next   = in_ovf_reg;
      slv_in_next   = slv_in_reg;
      rdata_next    = 8'h00;
      if (i_wr) begin
         case (i_addr)
            `DPG_OFS_PD_PIN,
            `DPG_OFS_PD_LAT: begin
               lat_d_next = i_wdata;
               if (slv_on) begin
                  out_full_next = 1'b1;
               end
            end
            `DPG_OFS_PD_DIR: dir_d_next = i_wdata;
            `DPG_OFS_PE_PIN,
            `DPG_OFS_PE_LAT: lat_e_next = i_wdata;
            `DPG_OFS_PE_DIR: dir_e_next = i_wdata;
            `DPG_OFS_SLVCTL: begin
               slv_mode_next = i_wdata[`DPG_SLV_MODE];
               // overflow clears only by writing zero
               in_ovf_next = in_ovf_reg & i_wdata[`DPG_SLV_INOVF];
            end
            `DPG_OFS_EXTMEM: extmem_next = i_wdata & `DPG_MEM_WMASK;
            default: ;
         endcase
      end
      if (i_rd) begin
         case (i_addr)
            `DPG_OFS_PD_PIN: begin
               if (slv_on) begin
                  rdata_next   = slv_in_reg;
                  in_full_next = 1'b0;
               end else begin
                  rdata_next = pd_s2_reg;
               end
            end
            `DPG_OFS_PD_LAT: rdata_next = lat_d_reg;
            `DPG_OFS_PD_DIR: rdata_next = dir_d_reg;
            `DPG_OFS_PE_PIN: rdata_next = pe_s2_reg;
            `DPG_OFS_PE_LAT: rdata_next = lat_e_reg;
            `DPG_OFS_PE_DIR: rdata_next = dir_e_reg;
            `DPG_OFS_SLVCTL: rdata_next = {in_full_reg, out_full_reg,
                                           in_ovf_reg, slv_mode_reg, 4'h0};
            `DPG_OFS_EXTMEM: rdata_next = extmem_reg;
            default:         rdata_next = 8'h00;
         endcase
      end
      // host events after software so a set beats a same-cycle clear
      if (wr_end) begin
         slv_in_next  = pd_s2_reg;
         in_full_next = 1'b1;
         if (in_full_reg) begin
            in_ovf_next = 1'b1;
         end
      end
      if (rd_end && !(i_wr && slv_on &&
          (i_addr == `DPG_OFS_PD_PIN || i_addr == `DPG_OFS_PD_LAT))) begin
         out_full_next = 1'b0;
      end
   end

   // pin drive and status outputs
   dpg_drive_t pd_next;
   dpg_drive_t pe_next;
   logic       ttl_next;

   always_comb begin
      // stored direction is never touched here, only the drive
      if (ext_bus) begin
         pd_next.dout = i_bus.ad_out[7:0];
         pd_next.oe   = {8{i_bus.oe}};
      end else if (slv_on) begin
         pd_next.dout = lat_d_reg;
         pd_next.oe   = host_rd ? 8'hff : 8'h00;
      end else begin
         pd_next.dout = lat_d_reg;
         pd_next.oe   = ~dir_d_reg;
      end
      if (ext_bus) begin
         pe_next.dout = i_bus.ad_out[15:8];
         pe_next.oe   = {8{i_bus.oe}};
      end else begin
         pe_next.dout = lat_e_reg;
         pe_next.oe   = ~dir_e_reg;
         if (slv_on) begin
            // forces e2..e0 to inputs whatever the stored directions are
            pe_next.oe[2:0] = 3'h0;
         end
         if (ccp_alt) begin
            pe_next.dout[`DPG_PE_CCP2] = i_ccp2_out;
            pe_next.oe[`DPG_PE_CCP2]   = i_ccp2_oe;
         end
      end
      ttl_next = ext_bus || slv_on;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lat_d_reg     <= `DPG_RST_LAT;
         dir_d_reg     <= `DPG_RST_DIR;
         lat_e_reg     <= `DPG_RST_LAT;
         dir_e_reg     <= `DPG_RST_DIR;
         extmem_reg    <= `DPG_RST_EXTMEM;
         slv_mode_reg  <= 1'b0;
         in_full_reg   <= 1'b0;
         out_full_reg  <= 1'b0;
         in_ovf_reg    <= 1'b0;
         slv_in_reg    <= 8'h00;
         wr_n_prev_reg <= 1'b1;
         rd_n_prev_reg <= 1'b1;
         o_rdata       <= 8'h00;
         o_pd_drv      <= '0;
         o_pe_drv      <= '0;
         o_pd_ttl_sel  <= 1'b0;
         o_pe_ttl_sel  <= 1'b0;
         o_bus_ad_in   <= 16'h0000;
         o_ccp2_in     <= 1'b0;
      end else begin
         lat_d_reg     <= lat_d_next;
         dir_d_reg     <= dir_d_next;
         lat_e_reg     <= lat_e_next;
         dir_e_reg     <= dir_e_next;
         extmem_reg    <= extmem_next;
         slv_mode_reg  <= slv_mode_next;
         in_full_reg   <= in_full_next;
         out_full_reg  <= out_full_next;
         in_ovf_reg    <= in_ovf_next;
         slv_in_reg    <= slv_in_next;
         wr_n_prev_reg <= pe_s2_reg[`DPG_PE_WR_N];
         rd_n_prev_reg <= pe_s2_reg[`DPG_PE_RD_N];
         o_rdata       <= rdata_next;
         o_pd_drv      <= pd_next;
         o_pe_drv      <= pe_next;
         o_pd_ttl_sel  <= ttl_next;
         o_pe_ttl_sel  <= ttl_next;
         o_bus_ad_in   <= {pe_s2_reg, pd_s2_reg};
         o_ccp2_in     <= pe_s2_reg[`DPG_PE_CCP2];
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   a_input_hiz: assert property (
      (!ext_bus && !slv_on && dir_d_reg[0]) |=> !o_pd_drv.oe[0])
      else $error("port d pin 0 driven while set as input");

   a_drive_latch: assert property (
      (!ext_bus && !slv_on && !dir_e_reg[3] && !ccp_alt)
      |=> o_pe_drv.oe[3] && (o_pe_drv.dout[3] == $past(lat_e_reg[3])))
      else $error("port e pin 3 not driven from its latch");

   a_latch_readback: assert property (
      (i_rd && i_addr == `DPG_OFS_PD_LAT) |=> o_rdata == $past(lat_d_reg))
      else $error("latch read did not return latch value");

   a_dir_stored: assert property (
      !(i_wr && i_addr == `DPG_OFS_PD_DIR) |=> $stable(dir_d_reg))
      else $error("direction changed without a write");

   a_bus_low: assert property (
      ext_bus |=> (o_pd_drv.dout == $past(i_bus.ad_out[7:0]))
                  && (o_pd_drv.oe == {8{$past(i_bus.oe)}}))
      else $error("port d not carrying bus low byte");

   a_bus_high: assert property (
      ext_bus |=> o_pe_drv.dout == $past(i_bus.ad_out[15:8]))
      else $error("port e not carrying bus high byte");

   a_slv_ctrl_in: assert property (
      (slv_on && !ext_bus) |=> o_pe_drv.oe[2:0] == 3'h0)
      else $error("slave port control pins driven");

   a_ttl_sel: assert property (
      slv_on |=> o_pd_ttl_sel && o_pe_ttl_sel)
      else $error("ttl thresholds not selected in slave mode");

   a_ccp_alt: assert property (
      (ccp_alt && !ext_bus) |=> o_pe_drv.oe[7] == $past(i_ccp2_oe))
      else $error("pin 7 not following capture unit 2");

   a_host_write: assert property (
      wr_end |=> in_full_reg ##0 (slv_in_reg == $past(pd_s2_reg)))
      else $error("host write not captured");

   a_unselected: assert property (
      (slv_on && pe_s2_reg[`DPG_PE_CS_N] && !ext_bus)
      |=> o_pd_drv.oe == 8'h00)
      else $error("port d driven while slave unselected");

endmodule

`default_nettype wire

// ### verif/dpg_host_model.sv
// far side of the pins: external host or memory driving the shared lines
// assumes the design drive wins over the host where both drive a line
`timescale 1ns/1ps
`default_nettype none

module dpg_host_model
   import dpg_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire dpg_drive_t i_pd_drv,
   input  wire dpg_drive_t i_pe_drv,
   input  wire logic [7:0] i_hd,
   input  wire logic [7:0] i_hd_en,
   input  wire logic [7:0] i_he,
   input  wire logic [7:0] i_he_en,
   output logic [7:0]      o_pd_pin,
   output logic [7:0]      o_pe_pin
);
   logic [7:0] flt_reg = 8'h5a;

   // no pull-ups: a floating line toggles so stale data never reads valid
   always @(posedge i_ref_clk) begin
      flt_reg <= ~flt_reg;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         o_pd_pin[i] = i_pd_drv.oe[i] ? i_pd_drv.dout[i] :
                       i_hd_en[i] ? i_hd[i] : flt_reg[i];
         // host read, write, select strobes are low active on e2..e0
         o_pe_pin[i] = i_pe_drv.oe[i] ? i_pe_drv.dout[i] :
                       i_he_en[i] ? i_he[i] : flt_reg[i];
      end
   end
endmodule

`default_nettype wire

// ### verif/tb_dpg_gpio.sv
// testbench for dpg_gpio: registers, pin muxing, slave port, bus modes
// assumes dpg_host_model resolves the shared pins
`include "dpg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_dpg_gpio
   import dpg_pkg::*;
;
   logic           clk, rst_n, wr, rd, sel, c_out, c_oe, ccp_in;
   logic           pd_ttl, pe_ttl;
   logic [2:0]     addr;
   logic [7:0]     wdata, rdata, pd_pin, pe_pin, hd, he, hd_en, he_en;
   logic [7:0]     d, lat, dir;
   logic [15:0]    bus_in, seed;
   dpg_mem_mode_t  mode;
   dpg_bus_drive_t bus;
   dpg_drive_t     pd_drv, pe_drv;
   int             fail_count, check_count;

   dpg_gpio u_dpg_gpio (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_pd_pin(pd_pin), .o_pd_drv(pd_drv), .i_pe_pin(pe_pin),
      .o_pe_drv(pe_drv), .i_mem_mode(mode),
      .i_capture_unit2_pin_select(sel), .i_bus(bus), .o_bus_ad_in(bus_in),
      .i_ccp2_out(c_out), .i_ccp2_oe(c_oe), .o_ccp2_in(ccp_in),
      .o_pd_ttl_sel(pd_ttl), .o_pe_ttl_sel(pe_ttl));

   dpg_host_model u_dpg_host_model (.i_ref_clk(clk), .i_pd_drv(pd_drv),
      .i_pe_drv(pe_drv), .i_hd(hd), .i_hd_en(hd_en), .i_he(he),
      .i_he_en(he_en), .o_pd_pin(pd_pin), .o_pe_pin(pe_pin));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [7:0] pin_exp(input logic [7:0] l, r, h);
      return (l & ~r) | (h & r);
   endfunction

   // dout is only meaningful where oe is high
   function automatic logic [15:0] drv_exp(input logic [7:0] l, r);
      return {l & ~r, ~r};
   endfunction

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      // look after the edge's updates have settled
      #1;
   endtask

   task automatic wreg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rchk(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, e});
   endtask

   task automatic close_out;
      if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      tick(3000);
      fail_count++;
      close_out;
   end

   initial begin
      {rst_n, addr, wdata, wr, rd, c_out, c_oe, hd} = '0;
      {he, hd_en, he_en} = '1;
      sel = 1'b1;
      mode = DPG_MODE_MCU;
      bus = '0;
      seed = 16'he9b0;
      fail_count = 0;
      check_count = 0;
      tick(2);
      rst_n <= 1'b1;
      rchk(`DPG_OFS_PD_DIR, 8'hff);
      rchk(`DPG_OFS_PE_DIR, 8'hff);
      chk({8'h00, pd_drv.oe}, 16'h0000);
      for (int i = 0; i < 14; i++) begin
         seed = lfsr(seed);
         lat = seed[7:0];
         dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[15:8];
         seed = lfsr(seed);
         hd <= seed[7:0];
         hd_en <= dir;
         he_en <= dir;
         wreg(`DPG_OFS_PD_LAT, lat);
         wreg(`DPG_OFS_PD_DIR, dir);
         wreg(`DPG_OFS_PE_PIN, lat);
         wreg(`DPG_OFS_PE_DIR, dir);
         tick(4);
         chk({pd_drv.dout & pd_drv.oe, pd_drv.oe}, drv_exp(lat, dir));
         chk({pe_drv.dout & pe_drv.oe, pe_drv.oe}, drv_exp(lat, dir));
         rchk(`DPG_OFS_PD_LAT, lat);
         rchk(`DPG_OFS_PE_LAT, lat);
         rchk(`DPG_OFS_PD_PIN, pin_exp(lat, dir, hd));
      end
      wreg(`DPG_OFS_PE_DIR, 8'hff);
      c_out <= 1'b1;
      c_oe <= 1'b1;
      sel <= 1'b0;
      tick(6);
      chk({14'h0, pe_drv.dout[7], pe_drv.oe[7]}, 16'h0003);
      chk({15'h0, ccp_in}, 16'h0001);
      sel <= 1'b1;
      tick(5);
      chk({15'h0, pe_drv.oe[7]}, 16'h0000);
      c_oe <= 1'b0;
      wreg(`DPG_OFS_PD_DIR, 8'hff);
      wreg(`DPG_OFS_PE_DIR, 8'h07);
      he <= 8'h07;
      he_en <= 8'h07;
      hd_en <= 8'hff;
      hd <= 8'hc3;
      wreg(`DPG_OFS_SLVCTL, 8'h10);
      tick(4);
      chk({15'h0, pd_ttl}, 16'h0001);
      he <= 8'h01;
      tick(4);
      he <= 8'h03;
      tick(4);
      he <= 8'h07;
      tick(4);
      rchk(`DPG_OFS_SLVCTL, 8'h90);
      rchk(`DPG_OFS_PD_PIN, 8'hc3);
      rchk(`DPG_OFS_SLVCTL, 8'h10);
      hd_en <= 8'h00;
      wreg(`DPG_OFS_PD_LAT, 8'h3c);
      rchk(`DPG_OFS_SLVCTL, 8'h50);
      he <= 8'h02;
      tick(5);
      chk({pd_drv.dout, pd_drv.oe}, 16'h3cff);
      he <= 8'h03;
      tick(5);
      rchk(`DPG_OFS_SLVCTL, 8'h10);
      he <= 8'h06;
      tick(5);
      chk({8'h00, pd_drv.oe}, 16'h0000);
      he <= 8'h07;
      wreg(`DPG_OFS_SLVCTL, 8'h00);
      seed = lfsr(seed);
      bus <= {seed, 1'b1};
      mode <= DPG_MODE_MPU;
      he_en <= 8'h00;
      wreg(`DPG_OFS_PD_DIR, 8'h0f);
      tick(6);
      chk({pd_drv.dout, pd_drv.oe}, {bus.ad_out[7:0], 8'hff});
      chk({pe_drv.dout, pe_drv.oe}, {bus.ad_out[15:8], 8'hff});
      chk({14'h0, pd_ttl, pe_ttl}, 16'h0003);
      chk(bus_in, bus.ad_out);
      rchk(`DPG_OFS_PD_DIR, 8'h0f);
      wreg(`DPG_OFS_EXTMEM, 8'hff);
      tick(4);
      rchk(`DPG_OFS_EXTMEM, 8'hb3);
      chk({pd_drv.dout & pd_drv.oe, pd_drv.oe}, drv_exp(8'h3c, 8'h0f));
      chk({8'h00, pe_drv.oe}, 16'h00f8);
      mode <= DPG_MODE_EXT_MCU;
      rst_n <= 1'b0;
      tick(2);
      rst_n <= 1'b1;
      tick(5);
      chk({pe_drv.dout, pe_drv.oe}, {bus.ad_out[15:8], 8'hff});
      rchk(`DPG_OFS_PD_DIR, 8'hff);
      close_out;
   end
endmodule

`default_nettype wire
